// *** src/clock_source_startup_select.sv ***
// Clock source selection, start-up delay sequencing and RC trim register.
//
// How it works
// - Low-frequency watch crystal is a selectable source.
// - Crystal wake delay 1k or 32k cycles.
// - Crystal reset delay 14CK plus 0/4.1/65ms.
// - Code 0010 selects the internal RC oscillator.
// - RC: wake 6CK, reset 14CK plus 0/4.1/65ms.
// - Reset-pin disable turns 14CK into 14CK+4.1ms.
// - Reset release loads factory byte into trim register.
// - Software may rewrite the 8-bit trim.
// - Trim bit 7 picks low or high range.
// - Ranges overlap: 0x7F above 0x80.
// - Trim bits 6..0 tune monotonically, small steps.
// - Reset time-out timed by watchdog-side clock.
// - Code 0011 selects the 128 kHz oscillator.
// - 128k: wake 6CK, reset 14CK plus 0/4/64ms.
// - Factory default: RC, slow-rise, divide-by-eight.
// - Prescaler resets to 0011 or 0000 by fuse.
`timescale 1ns/10ps
`include "clock_startup_defs.svh"

module clock_source_startup_select #(
    parameter logic [19:0] TO_4P1MS_CYC =
        20'((`TO_4P1MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
    parameter logic [19:0] TO_65MS_CYC =
        20'((`TO_65MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
    parameter logic [19:0] TO_4MS_CYC =
        20'((`TO_4MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
    parameter logic [19:0] TO_64MS_CYC =
        20'((`TO_64MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] clock_source_select_fuses_in,
    input wire logic [1:0] startup_time_fuses_in,
    input wire logic reset_pin_disable_fuse_in,
    input wire logic divide_by_eight_fuse_in,
    input wire logic fuses_erased_in,
    input wire clock_startup_pkg::trim_t factory_cal_in,
    input wire logic src_tick_in,
    input wire logic sleep_req_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic clock_enable_out,
    output logic sel_lf_crystal_out,
    output logic sel_rc_out,
    output logic sel_128k_out,
    output logic config_error_out,
    output clock_startup_pkg::trim_t rc_oscillator_trim_out,
    output logic [3:0] prescaler_select_field_out
);
    import clock_startup_pkg::*;

    // Pin synchronisers: stage one feeds stage two only.
    logic [18:0] sync1_r;
    logic [18:0] sync2_r;
    logic tick_d_r;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_r <= 19'h0_0000;
            sync2_r <= 19'h0_0000;
            tick_d_r <= 1'b0;
        end else begin
            sync1_r <= {clock_source_select_fuses_in, startup_time_fuses_in,
                        reset_pin_disable_fuse_in, divide_by_eight_fuse_in,
                        fuses_erased_in, factory_cal_in, src_tick_in,
                        sleep_req_in};
            sync2_r <= sync1_r;
            tick_d_r <= sync2_r[1];
        end
    end

    logic [3:0] srcsel_s;
    logic [1:0] stc_s;
    logic rstdis_s;
    logic div8_s;
    logic erased_s;
    trim_t cal_s;
    logic tick;
    logic sleep_s;
    assign srcsel_s = sync2_r[18:15];
    assign stc_s = sync2_r[14:13];
    assign rstdis_s = sync2_r[12];
    assign div8_s = sync2_r[11];
    assign erased_s = sync2_r[10];
    assign cal_s = sync2_r[9:2];
    assign tick = sync2_r[1] & ~tick_d_r;
    assign sleep_s = sync2_r[0];

    startup_state_e state_r;
    startup_state_e state_nxt;
    logic [1:0] smp_cnt_r;
    logic [3:0] srcsel_r;
    logic [1:0] stc_r;
    logic rstdis_r;
    logic div8_r;
    logic [19:0] ms_cnt_r;
    logic [15:0] ck_cnt_r;

    // Erased fuses fall back to the shipped source, start-up and divide-by-eight settings; reset-pin disable is taken as read.
    logic [3:0] srcsel_eff;
    logic [1:0] stc_eff;
    logic div8_eff;
    logic cfg_ok;
    assign srcsel_eff = erased_s ? `FACTORY_SRCSEL : srcsel_s;
    assign stc_eff = erased_s ? `FACTORY_STC : stc_s;
    assign div8_eff = erased_s ? `FACTORY_DIV8 : div8_s;
    assign cfg_ok = (stc_eff != `STC_RSVD) &&
                    (srcsel_eff == `SRCSEL_RC ||
                     srcsel_eff == `SRCSEL_128K ||
                     srcsel_eff[3:1] == `SRCSEL_LF_HI);

    logic is_lf;
    logic is_128k;
    assign is_lf = srcsel_r[3:1] == `SRCSEL_LF_HI;
    assign is_128k = srcsel_r == `SRCSEL_128K;

    logic [19:0] ms_target;
    always_comb begin
        case (stc_r)
            `STC_14CK: ms_target = rstdis_r ? TO_4P1MS_CYC : 20'h0_0000;
            `STC_4MS: ms_target = is_128k ? TO_4MS_CYC : TO_4P1MS_CYC;
            `STC_65MS: ms_target = is_128k ? TO_64MS_CYC : TO_65MS_CYC;
            default: ms_target = 20'h0_0000;
        endcase
    end

    logic [15:0] wake_target;
    always_comb begin
        if (is_lf) begin
            wake_target = srcsel_r[0] ? `WAKE_LF_LONG_CK
                                      : `WAKE_LF_SHORT_CK;
        end else begin
            wake_target = `WAKE_INT_CK;
        end
    end

    logic ck_done;
    assign ck_done = tick && (ck_cnt_r + 16'h0001 >=
        ((state_r == ST_WAKE) ? wake_target : `RESET_BASE_CK));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SAMPLE: begin
                if (smp_cnt_r == `SYNC_WAIT) begin
                    state_nxt = cfg_ok ? ST_TIMEOUT : ST_HALT;
                end
            end
            ST_TIMEOUT: begin
                if (ms_cnt_r >= ms_target) begin
                    state_nxt = ST_BASE;
                end
            end
            ST_BASE: begin
                if (ck_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_s) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleep_s) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (ck_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_HALT: state_nxt = ST_HALT;
            default: state_nxt = ST_HALT;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_SAMPLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Synchronisers need two edges before the fuse levels can be trusted.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            smp_cnt_r <= 2'h0;
        end else if (state_r == ST_SAMPLE && smp_cnt_r != `SYNC_WAIT) begin
            smp_cnt_r <= smp_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            srcsel_r <= 4'h0;
            stc_r <= 2'h0;
            rstdis_r <= 1'b0;
            div8_r <= 1'b0;
        end else if (state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT) begin
            srcsel_r <= srcsel_eff;
            stc_r <= stc_eff;
            rstdis_r <= rstdis_s;
            div8_r <= div8_eff;
        end
    end

    // The system clock stands in for the watchdog oscillator here, so the
    // millisecond time-out runs whatever source was picked.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ms_cnt_r <= 20'h0_0000;
        end else if (state_r == ST_TIMEOUT) begin
            ms_cnt_r <= ms_cnt_r + 20'h0_0001;
        end else begin
            ms_cnt_r <= 20'h0_0000;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ck_cnt_r <= 16'h0000;
        end else if (state_r != state_nxt) begin
            ck_cnt_r <= 16'h0000;
        end else if (tick && (state_r == ST_BASE || state_r == ST_WAKE)) begin
            ck_cnt_r <= ck_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_enable_out <= 1'b0;
            sel_lf_crystal_out <= 1'b0;
            sel_rc_out <= 1'b0;
            sel_128k_out <= 1'b0;
            config_error_out <= 1'b0;
        end else begin
            clock_enable_out <= state_nxt == ST_RUN;
            sel_lf_crystal_out <= is_lf && state_r != ST_SAMPLE;
            sel_rc_out <= srcsel_r == `SRCSEL_RC && state_r != ST_SAMPLE;
            sel_128k_out <= is_128k && state_r != ST_SAMPLE;
            config_error_out <= state_nxt == ST_HALT;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prescaler_select_field_out <= `PRESC_DIV1;
        end else if (state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT) begin
            prescaler_select_field_out <=
                div8_eff ? `PRESC_DIV8 : `PRESC_DIV1;
        end
    end

    // AXI4-Lite slave: one write and one read at a time.
    logic wr_go;
    logic rd_go;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                   !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr == `ADDR_TRIM) ? `RESP_OKAY
                                                             : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Trim register: factory byte at reset release, software after that.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rc_oscillator_trim_out <= `TRIM_RST;
        end else if (state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT) begin
            rc_oscillator_trim_out <= cal_s;
        end else if (s_axi_awready && s_axi_awaddr == `ADDR_TRIM &&
                     s_axi_wstrb[0]) begin
            rc_oscillator_trim_out <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_TRIM: s_axi_rdata <= {24'h00_0000,
                                                rc_oscillator_trim_out};
                    `ADDR_STATUS: s_axi_rdata <= {24'h00_0000,
                        config_error_out, state_r, sel_128k_out,
                        sel_rc_out, sel_lf_crystal_out, clock_enable_out};
                    `ADDR_CONFIG: s_axi_rdata <= {20'h0_0000, div8_r,
                        rstdis_r, stc_r, srcsel_r, prescaler_select_field_out};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_rc_select: assert property (
        state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT &&
        srcsel_eff == `SRCSEL_RC && cfg_ok |=> ##1 sel_rc_out)
        else $error("RC source not reported after code 0010");
    a_slow_select: assert property (
        sel_128k_out |-> srcsel_r == `SRCSEL_128K && !sel_rc_out)
        else $error("128 kHz source flagged with wrong code");
    a_lf_wake_len: assert property (
        state_r == ST_WAKE && is_lf |->
        wake_target == (srcsel_r[0] ? 16'h8000 : 16'h0400))
        else $error("crystal wake length wrong");
    a_int_wake_len: assert property (
        state_r == ST_WAKE && !is_lf |-> wake_target == 16'h0006)
        else $error("internal source wake length not six");
    a_rstdis_stretch: assert property (
        state_r == ST_TIMEOUT && stc_r == 2'h0 |->
        ms_target == (rstdis_r ? TO_4P1MS_CYC : 20'h0_0000))
        else $error("reset-pin disable stretch wrong");
    a_long_timeout: assert property (
        state_r == ST_TIMEOUT && stc_r == 2'h2 |->
        ms_target == (is_128k ? TO_64MS_CYC : TO_65MS_CYC))
        else $error("long reset time-out wrong");
    a_factory_trim: assert property (
        state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT |=>
        rc_oscillator_trim_out == $past(cal_s))
        else $error("factory trim not loaded");
    a_trim_write: assert property (
        s_axi_awready && s_axi_awaddr == `ADDR_TRIM && s_axi_wstrb[0] &&
        state_r != ST_SAMPLE |=>
        rc_oscillator_trim_out == $past(s_axi_wdata[7:0]))
        else $error("trim write lost");
    a_presc_reset: assert property (
        state_r == ST_SAMPLE && smp_cnt_r == `SYNC_WAIT |=>
        prescaler_select_field_out == ($past(div8_eff) ? 4'h3 : 4'h0))
        else $error("prescaler reset value wrong");
    a_clock_held: assert property (
        clock_enable_out |-> state_r == ST_RUN)
        else $error("clock released before start-up done");
    a_timeout_count: assert property (
        state_r == ST_TIMEOUT && $past(state_r) == ST_TIMEOUT |->
        ms_cnt_r == $past(ms_cnt_r) + 20'h0_0001)
        else $error("time-out counter stalled");
    a_cfg_static: assert property (
        state_r != ST_SAMPLE && $past(state_r) != ST_SAMPLE |->
        $stable(srcsel_r) && $stable(stc_r))
        else $error("configuration changed in operation");
endmodule

// *** include/clock_startup_defs.svh ***
// Offsets, field values, reset values and timing figures of the clock start-up block.
`ifndef CLOCK_STARTUP_DEFS_SVH
`define CLOCK_STARTUP_DEFS_SVH

`define CLK_PERIOD_NS 100
`define TO_4P1MS_NS 4100000
`define TO_65MS_NS 65000000
`define TO_4MS_NS 4000000
`define TO_64MS_NS 64000000

`define RESET_BASE_CK 16'h000e
`define WAKE_LF_SHORT_CK 16'h0400
`define WAKE_LF_LONG_CK 16'h8000
`define WAKE_INT_CK 16'h0006

`define SRCSEL_RC 4'h2
`define SRCSEL_128K 4'h3
`define SRCSEL_LF_HI 3'h3

`define STC_14CK 2'h0
`define STC_4MS 2'h1
`define STC_65MS 2'h2
`define STC_RSVD 2'h3

`define PRESC_DIV1 4'h0
`define PRESC_DIV8 4'h3

`define FACTORY_SRCSEL 4'h2
`define FACTORY_STC 2'h2
`define FACTORY_DIV8 1'h1

`define TRIM_RST 8'h80

`define ADDR_TRIM 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define ADDR_CONFIG 32'h0000_0008

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define SYNC_WAIT 2'h2

`endif

// *** include/clock_startup_pkg.sv ***
// Types shared by the clock start-up block.
package clock_startup_pkg;
    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b000,
        ST_TIMEOUT = 3'b001,
        ST_BASE = 3'b010,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b100,
        ST_WAKE = 3'b101,
        ST_HALT = 3'b110
    } startup_state_e;

    typedef logic [7:0] trim_t;
endpackage

// *** tb/watch_crystal_model.sv ***
// Behavioural watch crystal that supplies source ticks to the block.
`timescale 1ns/10ps
module watch_crystal_model #(
    parameter int HALF = 3
) (
    input wire logic sys_clk_in,
    output logic tick_out
);
    int cnt = 0;
    initial tick_out = 1'b0;
    // A crystal keeps swinging whether selected or not, so the tick runs free.
    always @(posedge sys_clk_in) begin
        if (cnt == HALF - 1) begin
            cnt <= 0;
            tick_out <= ~tick_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// *** tb/test_clock_source_startup_select.sv ***
// Self-checking bench for clock source selection, start-up and trim.
`timescale 1ns/10ps
`include "clock_startup_defs.svh"
module test_clock_source_startup_select;
    import clock_startup_pkg::*;
    localparam int HALF = 3;
    localparam int P = 2 * HALF;
    localparam int T41 = 20;
    localparam int T65 = 60;
    localparam int T4 = 18;
    localparam int T64 = 50;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] srcsel = 4'h2;
    logic [1:0] stc = 2'h0;
    logic rstdis = 1'b0;
    logic div8 = 1'b0;
    logic erased = 1'b0;
    trim_t cal = 8'h00;
    logic tick;
    logic sleep_req = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic clk_en, sel_lf, sel_rc, sel_128k, cfg_err;
    trim_t trim;
    logic [3:0] presc;
    int n_mismatch = 0;
    int total_checks = 0;

    initial forever #50 sys_clk = ~sys_clk;

    watch_crystal_model #(.HALF(HALF)) i_xtal (
        .sys_clk_in(sys_clk), .tick_out(tick));

    clock_source_startup_select #(
        .TO_4P1MS_CYC(20'(T41)), .TO_65MS_CYC(20'(T65)),
        .TO_4MS_CYC(20'(T4)), .TO_64MS_CYC(20'(T64))
    ) i_dut (
        .sys_clk_in(sys_clk), .resetn_in(resetn),
        .clock_source_select_fuses_in(srcsel), .startup_time_fuses_in(stc),
        .reset_pin_disable_fuse_in(rstdis), .divide_by_eight_fuse_in(div8),
        .fuses_erased_in(erased), .factory_cal_in(cal),
        .src_tick_in(tick), .sleep_req_in(sleep_req),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clock_enable_out(clk_en), .sel_lf_crystal_out(sel_lf),
        .sel_rc_out(sel_rc), .sel_128k_out(sel_128k),
        .config_error_out(cfg_err), .rc_oscillator_trim_out(trim),
        .prescaler_select_field_out(presc));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic stall(input int got, input int lim);
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lim);
        report_and_stop();
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_span(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got,
                lo, hi);
        end
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) stall(n, 50);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) stall(n, 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    function automatic int exp_to(logic [3:0] c, logic [1:0] s, logic rd);
        if (s == `STC_14CK) return rd ? T41 : 0;
        if (s == `STC_4MS) return (c == `SRCSEL_128K) ? T4 : T41;
        return (c == `SRCSEL_128K) ? T64 : T65;
    endfunction

    task automatic run_case(input logic [3:0] c, input logic [1:0] s,
            input logic rd, input logic d8, input logic er);
        logic [3:0] ec;
        logic [1:0] es;
        logic e8, err, lf;
        logic [31:0] d;
        logic [1:0] r;
        int n, to, wk, lim;
        ec = er ? `FACTORY_SRCSEL : c;
        es = er ? `FACTORY_STC : s;
        e8 = er ? `FACTORY_DIV8 : d8;
        lf = (ec[3:1] == `SRCSEL_LF_HI);
        err = es == `STC_RSVD ||
              !(lf || ec == `SRCSEL_RC || ec == `SRCSEL_128K);
        to = exp_to(ec, es, rd);
        wk = lf ? (ec[0] ? 32'h0000_8000 : 32'h0000_0400) : 32'h0000_0006;
        @(posedge sys_clk);
        resetn <= 1'b0;
        srcsel <= c;
        stc <= s;
        rstdis <= rd;
        div8 <= d8;
        erased <= er;
        cal <= trim_t'($urandom);
        sleep_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk_val(trim, `TRIM_RST);
        chk_val(clk_en, 1'b0);
        resetn <= 1'b1;
        n = 0;
        while (clk_en !== 1'b1 && cfg_err !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2000) stall(n, 2000);
        chk_val(cfg_err, err);
        if (err) begin
            repeat (200) @(posedge sys_clk);
            chk_val(clk_en, 1'b0);
        end else begin
            chk_span(n, to + 13 * P, to + 14 * P + 12);
            chk_val(trim, cal);
            chk_val(presc, e8 ? `PRESC_DIV8 : `PRESC_DIV1);
            // Fuse pins wander after start-up; captured values must hold.
            srcsel <= 4'($urandom);
            stc <= 2'($urandom);
            repeat (5) @(posedge sys_clk);
            chk_val({sel_lf, sel_rc, sel_128k},
                {lf, ec == `SRCSEL_RC, ec == `SRCSEL_128K});
            axi_rd(`ADDR_CONFIG, d, r);
            chk_val(d, {e8, rd, es, ec, e8 ? `PRESC_DIV8 : `PRESC_DIV1});
            sleep_req <= 1'b1;
            n = 0;
            while (clk_en === 1'b1 && n < 10) begin
                @(posedge sys_clk);
                n++;
            end
            chk_span(n, 1, 5);
            repeat (4) @(posedge sys_clk);
            sleep_req <= 1'b0;
            lim = (wk > 1024) ? 1024 * P + 40 : wk * P + 40;
            n = 0;
            while (clk_en !== 1'b1 && n < lim) begin
                @(posedge sys_clk);
                n++;
            end
            if (wk > 1024) begin
                chk_val(clk_en, 1'b0);
            end else begin
                if (n >= lim) stall(n, lim);
                chk_span(n, (wk - 1) * P, wk * P + 12);
            end
        end
        $display("case source %h start code %h done", c, s);
    endtask

    task automatic trim_test();
        logic [31:0] d, q;
        logic [1:0] r;
        axi_rd(`ADDR_STATUS, q, r);
        chk_val(q, 32'h0000_0035);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'h0000_007f : (i == 1) ? 32'h0000_0080 :
                (i == 2) ? 32'h0000_0000 : $urandom;
            axi_wr(`ADDR_TRIM, d, 4'hf, r);
            chk_val(r, `RESP_OKAY);
            chk_val(trim, d[7:0]);
            axi_rd(`ADDR_TRIM, q, r);
            chk_val(q, {24'h00_0000, d[7:0]});
        end
        axi_wr(`ADDR_TRIM, ~d, 4'he, r);
        chk_val(trim, d[7:0]);
        axi_wr(`ADDR_STATUS, ~d, 4'hf, r);
        chk_val({r, trim}, {`RESP_SLVERR, d[7:0]});
        axi_wr(32'h0000_0010, ~d, 4'hf, r);
        chk_val({r, trim}, {`RESP_SLVERR, d[7:0]});
        axi_rd(32'h0000_0010, q, r);
        chk_val({r, q}, {`RESP_SLVERR, 32'h0000_0000});
        $display("trim register test done");
    endtask

    initial begin
        void'($urandom(32'h981ae7de));
        run_case(4'h2, 2'h0, 1'b0, 1'b0, 1'b0);
        trim_test();
        run_case(4'h2, 2'h1, 1'b0, 1'b1, 1'b0);
        run_case(4'h2, 2'h2, 1'b0, 1'b0, 1'b0);
        run_case(4'h3, 2'h0, 1'b0, 1'b0, 1'b0);
        run_case(4'h3, 2'h1, 1'b0, 1'b0, 1'b0);
        run_case(4'h3, 2'h2, 1'b0, 1'b1, 1'b0);
        run_case(4'h6, 2'h0, 1'b0, 1'b0, 1'b0);
        run_case(4'h7, 2'h1, 1'b0, 1'b0, 1'b0);
        run_case(4'h6, 2'h2, 1'b0, 1'b0, 1'b0);
        run_case(4'h2, 2'h0, 1'b1, 1'b0, 1'b0);
        run_case(4'h3, 2'h0, 1'b1, 1'b0, 1'b0);
        run_case(4'h5, 2'h0, 1'b0, 1'b0, 1'b1);
        run_case(4'h2, 2'h3, 1'b0, 1'b0, 1'b0);
        run_case(4'h3, 2'h3, 1'b0, 1'b0, 1'b0);
        run_case(4'h6, 2'h3, 1'b0, 1'b0, 1'b0);
        run_case(4'h9, 2'h0, 1'b0, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule
